// *** hw/ulpi_rxcmd_pkg.sv ***
// Shared constants and types for the receive-command generator
package ulpi_rxcmd_pkg;

  // ----------------------------------------------------------------
  // Bus command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] BUS_IDLE = 8'h00;  // Link idle byte
  localparam logic [1:0] TXCMD_TRANSMIT = 2'h1;  // Upper bits: packet tx
  localparam int TXCMD_TOP = 7;  // Top bit of command field
  localparam int TXCMD_BOT = 6;  // Bottom bit of command field

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] VBUS_BELOW_END = 2'h0;  // Below session end
  localparam logic [1:0] VBUS_END_TO_SESS = 2'h1;  // End to session valid
  localparam logic [1:0] VBUS_SESS_TO_VALID = 2'h2;  // Session to valid
  localparam logic [1:0] VBUS_ABOVE_VALID = 2'h3;  // Above vbus valid
  localparam logic [1:0] EVT_NONE = 2'h0;  // Nothing active
  localparam logic [1:0] EVT_RX_ACTIVE = 2'h1;  // Receive active
  localparam logic [1:0] EVT_RX_ERROR = 2'h3;  // Active with error
  localparam logic [1:0] EVT_HOST_DISC = 2'h2;  // Host disconnect
  localparam int CARKIT_W = 5;  // Carkit interrupt latch width

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Receive-command byte, bit 7 first
  typedef struct packed {
    logic altInt;  // Non-USB interrupt flag
    logic idLevel;  // ID pin level
    logic [1:0] rxEvent;  // Encoded receive event
    logic [1:0] vbusLevel;  // Encoded VBUS level
    logic [1:0] lineState;  // Line state
  } rx_cmd_t;

  // Analog and core status gathered on the system clock
  typedef struct packed {
    logic seDp;  // DP single-ended receiver
    logic seDm;  // DM single-ended receiver
    logic hsMode;  // High-speed operation
    logic squelch;  // High-speed squelch detector
    logic session_end_flag;  // Below session end
    logic session_valid_flag;  // Above session valid
    logic vbus_valid_flag;  // Above vbus valid
    logic idPin;  // ID comparator
    logic altInt;  // Unmasked carkit interrupt pending
    logic asyncMode;  // Low power, serial or carkit mode active
  } status_t;

  localparam int STATUS_W = $bits(status_t);  // Width of crossing bus

endpackage

// *** hw/level_sync.sv ***
// Two-flop level synchroniser, also used as a reset release synchroniser
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels from another domain
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  logic [W-1:0] stage1;  // Metastable stage, read only by stage two

  // Capture then settle; only constants under reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule
`default_nettype wire

// *** hw/ulpi_rx_command_generator.sv ***
// Receive-command generator facing the ULPI link on the interface clock
//
// Behaviour
// - Send status whenever shared bus idles
// - Raise DIR first to take the bus
// - Single or back-to-back bytes under DIR
// - Transfers only in synchronous mode, DIR high
// - Line state change schedules a byte
// - VBUS or ID comparator change schedules byte
// - Receive with NXT low carries status byte
// - Start-up byte once DIR low, STP low
// - Byte after async exit, STP low
// - Withhold bytes while link transmits packet
// - High-speed transmit holds bytes until STP falls
// - Byte carries status sampled when driven
// - Bits one, zero hold line state
// - Bits three, two encode VBUS level
// - Bits five, four encode receive events
// - Bit six mirrors ID pin level
// - Bit seven flags unmasked carkit interrupt
// - Turnaround cycle after DIR change, bus ignored
// - Signalling changes on interface clock rising edge
// - Full/low speed line state from receivers
// - High-speed line state shows squelch only
`timescale 1ns/1ps
`default_nettype none
module ulpi_rx_command_generator (
  // System clock domain
  input wire logic sys_clk,
  input wire logic rst_n,
  // Analog status, system domain
  input wire logic seDp,
  input wire logic seDm,
  input wire logic hsMode,
  input wire logic squelch,
  input wire logic session_end_flag,
  input wire logic session_valid_flag,
  input wire logic vbus_valid_flag,
  input wire logic idPin,
  input wire logic asyncMode,
  // Carkit interrupt latch and mask, system domain
  input wire logic [ulpi_rxcmd_pkg::CARKIT_W-1:0] carkitLatch,
  input wire logic [ulpi_rxcmd_pkg::CARKIT_W-1:0] carkitMask,
  // Interface clock
  input wire logic ulpiClk,
  // Receiver events, interface domain
  input wire logic rxActive,
  input wire logic rxError,
  input wire logic hostDisconnect,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  // ULPI pins
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic dir,
  output logic nxt,
  input wire logic stp
);

  // ----------------------------------------------------------------
  // System domain status capture
  // ----------------------------------------------------------------
  ulpi_rxcmd_pkg::status_t sysStatus;  // Registered before crossing
  ulpi_rxcmd_pkg::status_t linkStatus;  // Synchronised copy
  logic ulpiRst_n;  // Reset released on the interface clock

  // Register so the synchroniser never sees a combinational glitch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysStatus <= '0;
    end else begin
      sysStatus.seDp <= seDp;
      sysStatus.seDm <= seDm;
      sysStatus.hsMode <= hsMode;
      sysStatus.squelch <= squelch;
      sysStatus.session_end_flag <= session_end_flag;
      sysStatus.session_valid_flag <= session_valid_flag;
      sysStatus.vbus_valid_flag <= vbus_valid_flag;
      sysStatus.idPin <= idPin;
      sysStatus.altInt <= |(carkitLatch & carkitMask);
      sysStatus.asyncMode <= asyncMode;
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the interface domain
  // ----------------------------------------------------------------
  // Each field is an independent level; a transient skew between
  // fields at most costs one extra status byte
  level_sync #(.W(ulpi_rxcmd_pkg::STATUS_W)) statusSync (
    .clk(ulpiClk),
    .rst_n(rst_n),
    .d(sysStatus),
    .q(linkStatus)
  );

  // Asynchronous assert, release timed to the interface clock
  level_sync #(.W(1)) resetSync (
    .clk(ulpiClk),
    .rst_n(rst_n),
    .d(1'b1),
    .q(ulpiRst_n)
  );

  // ----------------------------------------------------------------
  // Field encoding
  // ----------------------------------------------------------------
  // Line state per operating speed
  function automatic logic [1:0] encodeLine(
    input ulpi_rxcmd_pkg::status_t s
  );
    // High speed only reports squelch; codes above one never appear
    if (s.hsMode) begin
      return {1'b0, ~s.squelch};
    end
    return {s.seDm, s.seDp};
  endfunction

  // VBUS level from the three comparators, highest first
  function automatic logic [1:0] encodeVbus(
    input ulpi_rxcmd_pkg::status_t s
  );
    if (s.vbus_valid_flag) begin
      return ulpi_rxcmd_pkg::VBUS_ABOVE_VALID;
    end
    if (s.session_valid_flag) begin
      return ulpi_rxcmd_pkg::VBUS_SESS_TO_VALID;
    end
    if (s.session_end_flag) begin
      return ulpi_rxcmd_pkg::VBUS_BELOW_END;
    end
    return ulpi_rxcmd_pkg::VBUS_END_TO_SESS;
  endfunction

  wire logic [1:0] rxEventCode;  // Disconnect outranks receive
  assign rxEventCode = hostDisconnect ? ulpi_rxcmd_pkg::EVT_HOST_DISC :
      !rxActive ? ulpi_rxcmd_pkg::EVT_NONE :
      rxError ? ulpi_rxcmd_pkg::EVT_RX_ERROR :
      ulpi_rxcmd_pkg::EVT_RX_ACTIVE;

  // Live status, sampled at drive time; one driver for the whole byte
  ulpi_rxcmd_pkg::rx_cmd_t curCmd;
  assign curCmd = '{
    altInt: linkStatus.altInt,
    idLevel: linkStatus.idPin,
    rxEvent: rxEventCode,
    vbusLevel: encodeVbus(linkStatus),
    lineState: encodeLine(linkStatus)
  };

  // ----------------------------------------------------------------
  // Bus sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,  // Link owns the bus
    ST_TURN,  // DIR just raised, nobody drives
    ST_CMD,  // Driving status bytes
    ST_RECV  // Packet receive in progress
  } bus_state_t;

  bus_state_t state;  // Current bus phase
  bus_state_t next_state;  // Phase after this edge
  ulpi_rxcmd_pkg::rx_cmd_t reported;  // Last status byte given to link
  logic turnFlag;  // Turnaround cycle after DIR fell
  logic txActive;  // Link is sending a packet
  logic txStopSeen;  // High-speed stop seen, waiting for STP low
  logic startReq;  // Start-up byte still owed
  logic asyncReq;  // Byte owed after leaving an async mode
  logic asyncPrev;  // Previous async mode level

  // ----------------------------------------------------------------
  // Scheduling decisions
  // ----------------------------------------------------------------
  wire logic asyncActive;  // No clocked transfers in async modes
  assign asyncActive = linkStatus.asyncMode;

  wire logic asyncExit;  // Falling edge of async mode
  assign asyncExit = asyncPrev && !asyncActive;

  wire logic statusChanged;  // Any field differs from last report
  assign statusChanged = curCmd != reported;

  // All causes merge into one flag, so a burst of events yields one
  // byte with the combined status
  wire logic pending;
  assign pending = statusChanged || startReq || asyncReq;

  wire logic linkBusy;  // Link driving a command, or turnaround
  assign linkBusy = turnFlag || (dataIn != ulpi_rxcmd_pkg::BUS_IDLE);

  wire logic txStart;  // Transmit command seen on an owned bus
  assign txStart = (state == ST_IDLE) && !turnFlag &&
      (dataIn[ulpi_rxcmd_pkg::TXCMD_TOP:ulpi_rxcmd_pkg::TXCMD_BOT] ==
      ulpi_rxcmd_pkg::TXCMD_TRANSMIT);

  wire logic canSend;  // Bus idle, no transmit, STP low
  assign canSend = !linkBusy && !txActive && !stp && !asyncActive;

  // Next phase of the bus
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        // Receive outranks status; status waits for an idle bus
        if (rxActive && !asyncActive) begin
          next_state = ST_TURN;
        end else if (canSend && pending) begin
          next_state = ST_TURN;
        end
      end
      ST_TURN: begin
        next_state = rxActive ? ST_RECV : ST_CMD;
      end
      ST_CMD: begin
        if (rxActive) begin
          next_state = ST_RECV;
        end else if (!statusChanged) begin
          next_state = ST_IDLE;
        end  // Otherwise a further byte follows
      end
      ST_RECV: begin
        // Leave only once the final status has been reported
        if (!rxActive && !statusChanged) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  wire logic sendStatus;  // Status byte driven in the next cycle
  assign sendStatus = (next_state == ST_CMD) ||
      ((next_state == ST_RECV) && !rxByteValid);

  wire logic next_nxt;  // NXT with DIR rise marks receive start
  assign next_nxt = ((next_state == ST_TURN) && rxActive) ||
      ((next_state == ST_RECV) && rxByteValid);

  wire logic [7:0] next_dataOut;  // Status sampled now
  assign next_dataOut = sendStatus ? curCmd : rxByte;

  // ----------------------------------------------------------------
  // Bus registers, all on the rising interface clock edge
  // ----------------------------------------------------------------
  // Phase and pin drivers
  always_ff @(posedge ulpiClk or negedge ulpiRst_n) begin
    if (!ulpiRst_n) begin
      state <= ST_IDLE;
      dir <= 1'b0;
      nxt <= 1'b0;
      dataOe <= 1'b0;
      dataOut <= ulpi_rxcmd_pkg::BUS_IDLE;
    end else begin
      state <= next_state;
      dir <= next_state != ST_IDLE;
      nxt <= next_nxt;
      // Never drive in the turnaround cycle
      dataOe <= (next_state == ST_CMD) || (next_state == ST_RECV);
      dataOut <= next_dataOut;
    end
  end

  // Remember what the link has been told
  always_ff @(posedge ulpiClk or negedge ulpiRst_n) begin
    if (!ulpiRst_n) begin
      reported <= '0;
    end else if (sendStatus) begin
      reported <= curCmd;
    end
  end

  // Turnaround after DIR falls; bus content is unknown then
  always_ff @(posedge ulpiClk or negedge ulpiRst_n) begin
    if (!ulpiRst_n) begin
      turnFlag <= 1'b0;
    end else begin
      turnFlag <= (state != ST_IDLE) && (next_state == ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Link transmit tracking
  // ----------------------------------------------------------------
  // Full/low speed frees the bus at STP; high speed waits for STP
  // to fall again, which costs one more cycle of deferral
  always_ff @(posedge ulpiClk or negedge ulpiRst_n) begin
    if (!ulpiRst_n) begin
      txActive <= 1'b0;
      txStopSeen <= 1'b0;
    end else if (!txActive) begin
      txActive <= txStart;
      txStopSeen <= 1'b0;
    end else if (txStopSeen) begin
      txActive <= stp;
    end else if (stp) begin
      txActive <= linkStatus.hsMode;
      txStopSeen <= linkStatus.hsMode;
    end
  end

  // ----------------------------------------------------------------
  // Owed bytes from start-up and async exit
  // ----------------------------------------------------------------
  // A new cause in the same cycle as delivery wins over the clear
  always_ff @(posedge ulpiClk or negedge ulpiRst_n) begin
    if (!ulpiRst_n) begin
      startReq <= 1'b1;
      asyncReq <= 1'b0;
      asyncPrev <= 1'b0;
    end else begin
      asyncPrev <= asyncActive;
      if (sendStatus) begin
        startReq <= 1'b0;
      end
      asyncReq <= asyncExit || (asyncReq && !sendStatus);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ulpiClk);
  endclocking
  default disable iff (!ulpiRst_n);

  sequence turnThenDrive;
    !dataOe ##1 dataOe;
  endsequence

  sequence ownBusForStatus;
    dir && !nxt ##0 turnThenDrive;
  endsequence

  dir_rise_turn_a: assert property (
    $rose(dir) |-> turnThenDrive)
    else $error("DIR rise not followed by turnaround then drive");

  cmd_sampled_a: assert property (
    dataOe && !nxt |-> dataOut == $past(curCmd))
    else $error("Status byte not sampled at drive time");

  recv_status_a: assert property (
    dir && $past(dir) && !nxt |-> dataOe && dataOut == $past(curCmd))
    else $error("Receive gap did not carry status byte");

  change_sends_a: assert property (
    state == ST_IDLE && statusChanged && canSend && !rxActive
      |=> ownBusForStatus)
    else $error("Status change not reported");

  startup_send_a: assert property (
    state == ST_IDLE && startReq && canSend && !rxActive
      |=> ##1 dataOe && !startReq)
    else $error("Start-up byte not delivered");

  tx_defers_a: assert property (
    state == ST_IDLE && txActive && !rxActive |=> !dir)
    else $error("Status byte sent during link transmit");

  hs_stop_hold_a: assert property (
    txActive && txStopSeen && stp && !rxActive |=> !dir ##1 !dir)
    else $error("High-speed deferral ended before STP fell");

  turn_ignored_a: assert property (
    $fell(dir) && !txActive |=> !txActive)
    else $error("Bus decoded during turnaround");

  vbus_code_a: assert property (
    dataOe && !nxt && $past(linkStatus.vbus_valid_flag)
      |-> dataOut[3:2] == ulpi_rxcmd_pkg::VBUS_ABOVE_VALID)
    else $error("VBUS level encoded wrongly");

  alt_flag_a: assert property (
    dataOe && !nxt |-> dataOut[7] == $past(linkStatus.altInt))
    else $error("Interrupt flag does not follow carkit latch");

  async_quiet_a: assert property (
    state == ST_IDLE && asyncActive |=> !dir)
    else $error("Bus taken during async mode");

endmodule
`default_nettype wire

// *** tb/ulpi_link_model.sv ***
// Behavioural link controller facing the receive-command generator
`timescale 1ns/1ps
`default_nettype none
module ulpi_link_model (
  // Interface clock and reset
  input wire logic ulpiClk,
  input wire logic rst_n,
  // Pins driven by the device
  input wire logic dir,
  input wire logic nxt,
  input wire logic dataOe,
  input wire logic [7:0] dataOut,
  // Pins driven by the link
  output logic [7:0] dataIn,
  output logic stp,
  // Bench controls
  input wire logic [7:0] linkByte,
  input wire logic stpReq,
  // Observations
  output logic [7:0] cmdByte,
  output logic [15:0] cmdCount,
  output logic altSeen
);
  // ----------------------------------------------------------------
  // Bus ownership
  // ----------------------------------------------------------------
  logic dirQ; // Direction seen on the previous edge
  logic [7:0] lastDrive; // Last byte the link really drove
  wire turnCycle = dir != dirQ; // Turnaround after any direction change
  // Released bus must not look like idle, so show the inverse of the
  // last driven value instead of a stale copy
  assign dataIn = (dir || turnCycle) ? ~lastDrive : linkByte;
  assign stp = stpReq; // Bench changes it just after the edge

  // Capture status bytes: device owns bus, past turnaround, NXT low
  always_ff @(posedge ulpiClk or negedge rst_n) begin
    if (!rst_n) begin
      dirQ <= 1'b0;
      lastDrive <= 8'h00;
      cmdByte <= 8'h00;
      cmdCount <= 16'h0000;
      altSeen <= 1'b0;
    end else begin
      dirQ <= dir;
      if (!dir && !turnCycle) begin
        lastDrive <= linkByte;
      end
      if (dir && dirQ && dataOe && !nxt) begin
        cmdByte <= dataOut;
        cmdCount <= cmdCount + 16'h0001;
        // Flag noted; a real link would now read the carkit latch
        if (dataOut[7]) begin
          altSeen <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/ulpi_rx_command_generator_bench.sv ***
// Self-checking bench for the receive-command generator
`timescale 1ns/1ps
`default_nettype none
module ulpi_rx_command_generator_bench;
  // ----------------------------------------------------------------
  // Clocks, reset and stimulus
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0; // 125 MHz system clock
  logic ulpiClk = 1'b0; // Link clock, 32 ns period
  logic rst_n = 1'b0; // Async reset, active low
  ulpi_rxcmd_pkg::status_t st; // Status levels, system domain
  logic [ulpi_rxcmd_pkg::CARKIT_W-1:0] latch; // Carkit latch
  logic [ulpi_rxcmd_pkg::CARKIT_W-1:0] mask; // Carkit mask
  logic rxActive;
  logic rxError;
  logic hostDisconnect;
  logic rxByteValid;
  logic [7:0] rxByte;
  logic [7:0] linkByte; // What the link drives while it owns the bus
  logic stpReq;
  logic [7:0] dataIn;
  logic [7:0] dataOut;
  logic [7:0] cmdByte; // Last status byte the link took
  logic dataOe;
  logic dir;
  logic nxt;
  logic stp;
  logic [15:0] cmdCount;
  logic altSeen; // Link noticed the interrupt flag
  logic [15:0] snap; // Byte count before a stimulus
  int n_mismatch = 0;
  int comparisons = 0;

  always #4 sys_clk = ~sys_clk;
  // Rising edges never meet a system rising edge
  always #16 ulpiClk = ~ulpiClk;

  ulpi_rx_command_generator u_ulpi_rx_command_generator (
    .sys_clk(sys_clk), .rst_n(rst_n), .seDp(st.seDp), .seDm(st.seDm),
    .hsMode(st.hsMode), .squelch(st.squelch),
    .session_end_flag(st.session_end_flag),
    .session_valid_flag(st.session_valid_flag),
    .vbus_valid_flag(st.vbus_valid_flag), .idPin(st.idPin),
    .asyncMode(st.asyncMode), .carkitLatch(latch), .carkitMask(mask),
    .ulpiClk(ulpiClk), .rxActive(rxActive), .rxError(rxError),
    .hostDisconnect(hostDisconnect), .rxByteValid(rxByteValid),
    .rxByte(rxByte), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .dir(dir), .nxt(nxt), .stp(stp)
  );

  ulpi_link_model u_ulpi_link_model (
    .ulpiClk(ulpiClk), .rst_n(rst_n), .dir(dir), .nxt(nxt),
    .dataOe(dataOe), .dataOut(dataOut), .dataIn(dataIn), .stp(stp),
    .linkByte(linkByte), .stpReq(stpReq), .cmdByte(cmdByte),
    .cmdCount(cmdCount), .altSeen(altSeen)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected byte from the levels the bench itself drives
  function automatic logic [7:0] expv(input ulpi_rxcmd_pkg::status_t s,
                                      input logic [1:0] ev,
                                      input logic ai);
    logic [1:0] ls;
    logic [1:0] vb;
    ls = s.hsMode ? {1'b0, ~s.squelch} : {s.seDm, s.seDp};
    if (s.vbus_valid_flag) begin
      vb = ulpi_rxcmd_pkg::VBUS_ABOVE_VALID;
    end else if (s.session_valid_flag) begin
      vb = ulpi_rxcmd_pkg::VBUS_SESS_TO_VALID;
    end else if (s.session_end_flag) begin
      vb = ulpi_rxcmd_pkg::VBUS_BELOW_END;
    end else begin
      vb = ulpi_rxcmd_pkg::VBUS_END_TO_SESS;
    end
    return {ai, s.idPin, ev, vb, ls};
  endfunction

  // New system-domain levels, launched on a system rising edge
  task automatic put(input ulpi_rxcmd_pkg::status_t s,
                     input logic [4:0] l, input logic [4:0] m);
    snap = cmdCount;
    @(posedge sys_clk);
    st <= s;
    latch <= l;
    mask <= m;
  endtask

  // Wait for a new byte, then for the bus to be handed back for good
  task automatic await_byte;
    int i;
    int q;
    i = 0;
    q = 0;
    while (cmdCount === snap && i < 300) begin
      @(posedge ulpiClk);
      i++;
    end
    // No byte at all ends as a timeout too
    if (cmdCount === snap) begin
      i = 600;
    end
    while (q < 6 && i < 600) begin
      @(posedge ulpiClk);
      i++;
      q = (dir === 1'b0) ? q + 1 : 0;
    end
    if (q < 6) begin
      n_mismatch++;
      $display("[FAIL] status byte wait expected done seen timeout");
      stop_test;
    end
  endtask

  task automatic expect_cmd(input string what, input logic [7:0] exp);
    await_byte;
    check8(what, exp, cmdByte);
  endtask

  // No status byte may appear for n link cycles
  task automatic quiet(input int n);
    snap = cmdCount;
    repeat (n) @(posedge ulpiClk);
    check8("withheld byte count", snap[7:0], cmdCount[7:0]);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ulpi_rxcmd_pkg::status_t s;
    logic [1:0] lsSeq [4];
    logic [2:0] vbSeq [4];
    s = '0;
    s.seDp = 1'b1;
    s.session_valid_flag = 1'b1;
    s.vbus_valid_flag = 1'b1;
    s.idPin = 1'b1;
    st = s;
    latch = '0;
    mask = '0;
    {rxActive, rxError, hostDisconnect, rxByteValid, stpReq} = 5'h00;
    rxByte = 8'h00;
    linkByte = 8'h00;
    snap = '0;
    // Orders chosen so every step really changes the level
    lsSeq = '{2'h0, 2'h2, 2'h3, 2'h1};
    vbSeq = '{3'h4, 3'h0, 3'h2, 3'h3};
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    expect_cmd("start-up byte", expv(s, 2'h0, 1'b0));
    // Line state in full speed, each code
    for (int i = 0; i < 4; i++) begin
      {s.seDm, s.seDp} = lsSeq[i];
      put(s, 5'h00, 5'h00);
      expect_cmd("line state", expv(s, 2'h0, 1'b0));
    end
    // Each VBUS band
    for (int i = 0; i < 4; i++) begin
      {s.session_end_flag, s.session_valid_flag, s.vbus_valid_flag} = vbSeq[i];
      put(s, 5'h00, 5'h00);
      expect_cmd("vbus level", expv(s, 2'h0, 1'b0));
    end
    for (int i = 0; i < 2; i++) begin
      s.idPin = ~s.idPin;
      put(s, 5'h00, 5'h00);
      expect_cmd("id level", expv(s, 2'h0, 1'b0));
    end
    // Masked carkit event stays silent, unmasked one raises the flag
    put(s, 5'h04, 5'h00);
    quiet(24);
    check8("link alt before", 8'h00, {7'h00, altSeen});
    put(s, 5'h04, 5'h04);
    expect_cmd("alt flag set", expv(s, 2'h0, 1'b1));
    check8("link alt seen", 8'h01, {7'h00, altSeen});
    put(s, 5'h00, 5'h04);
    expect_cmd("alt flag clear", expv(s, 2'h0, 1'b0));
    // Receive: status bytes in NXT-low cycles, dir held throughout
    @(posedge ulpiClk);
    rxActive <= 1'b1;
    repeat (10) @(posedge ulpiClk);
    rxByteValid <= 1'b1;
    rxByte <= 8'h5a;
    @(posedge ulpiClk);
    rxByteValid <= 1'b0;
    repeat (4) @(posedge ulpiClk);
    check8("dir in receive", 8'h01, {7'h00, dir});
    check8("rx active", expv(s, 2'h1, 1'b0), cmdByte);
    rxError <= 1'b1;
    repeat (8) @(posedge ulpiClk);
    check8("rx error", expv(s, 2'h3, 1'b0), cmdByte);
    rxActive <= 1'b0;
    rxError <= 1'b0;
    hostDisconnect <= 1'b1;
    snap = cmdCount;
    expect_cmd("disconnect", expv(s, 2'h2, 1'b0));
    @(posedge ulpiClk);
    hostDisconnect <= 1'b0;
    snap = cmdCount;
    expect_cmd("events idle", expv(s, 2'h0, 1'b0));
    // High-speed line state follows squelch only
    s.hsMode = 1'b1;
    s.squelch = 1'b1;
    put(s, 5'h00, 5'h00);
    expect_cmd("hs squelch on", expv(s, 2'h0, 1'b0));
    s.squelch = 1'b0;
    put(s, 5'h00, 5'h00);
    expect_cmd("hs squelch off", expv(s, 2'h0, 1'b0));
    // High-speed transmit: two events withheld, one byte after stop
    @(posedge ulpiClk);
    linkByte <= {ulpi_rxcmd_pkg::TXCMD_TRANSMIT, 6'h01};
    repeat (2) @(posedge ulpiClk);
    s.squelch = 1'b1;
    put(s, 5'h00, 5'h00);
    quiet(20);
    s.idPin = ~s.idPin;
    put(s, 5'h00, 5'h00);
    quiet(12);
    @(posedge ulpiClk);
    linkByte <= 8'h00;
    stpReq <= 1'b1;
    // Two cycles of STP so the hold-off after the stop is exercised
    repeat (2) @(posedge ulpiClk);
    stpReq <= 1'b0;
    snap = cmdCount;
    expect_cmd("after transmit", expv(s, 2'h0, 1'b0));
    check8("bytes after transmit", 8'h01, cmdCount[7:0] - snap[7:0]);
    // Asynchronous mode: silent, then one byte on exit
    s.asyncMode = 1'b1;
    put(s, 5'h00, 5'h00);
    quiet(10);
    s.idPin = ~s.idPin;
    put(s, 5'h00, 5'h00);
    quiet(20);
    s.asyncMode = 1'b0;
    put(s, 5'h00, 5'h00);
    expect_cmd("async exit", expv(s, 2'h0, 1'b0));
    check8("bytes after exit", 8'h01, cmdCount[7:0] - snap[7:0]);
    // Async round trip with no status change still owes one byte
    s.asyncMode = 1'b1;
    put(s, 5'h00, 5'h00);
    quiet(10);
    s.asyncMode = 1'b0;
    put(s, 5'h00, 5'h00);
    expect_cmd("bare async exit", expv(s, 2'h0, 1'b0));
    stop_test;
  end
endmodule
`default_nettype wire
